// file: core/card_csc_consts.svh
// Offsets, field positions, reset values for the status-change block
`ifndef CARD_CSC_CONSTS_SVH
`define CARD_CSC_CONSTS_SVH

// ==========================================================================
// Register offsets
`define SOCK_OFS_FLAGS 12'h804
`define SOCK_OFS_CFG 12'h805
`define SOCK_OFS_WIN 12'h806
`define LEGACY_IDX_FLAGS 8'h04
`define LEGACY_IDX_CFG 8'h05
`define LEGACY_IDX_WIN 8'h06

// ==========================================================================
// Reset values
`define CFG_RESET 8'h00
`define WIN_RESET 8'h00
`define FLAGS_RESET 4'h0

// ==========================================================================
// Configuration register fields
`define CFG_SELECT_MSB 7
`define CFG_SELECT_LSB 4
`define CFG_BIT_CARD_DETECT 3
`define CFG_BIT_READY 2
`define CFG_BIT_BATT_WARN 1
`define CFG_BIT_BATT_DEAD 0
`define SELECT_NONE 4'h0
`define SELECT_SMI 4'h2

// ==========================================================================
// Window enable register fields
`define WIN_BIT_IO1 7
`define WIN_BIT_IO0 6
`define WIN_BIT_RSVD 5
`define WIN_MEM_MSB 4
`define WIN_WRITE_MASK 8'hDF

`endif

// file: core/card_csc_flags.sv
// Sticky status-change flags with enable masking and two clear modes
`timescale 1ns/1ps
`default_nettype none
`include "card_csc_consts.svh"

module card_csc_flags (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Sources and masks
  input wire logic [3:0] setEvt,
  input wire logic [3:0] enable,
  // Clearing
  input wire logic clearByWrite,
  input wire logic rdStrobe,
  input wire logic wrStrobe,
  input wire logic [3:0] wrData,
  // State
  output var logic [3:0] flags
);

  // ========================================================================
  // One flag per source
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : gFlag
      logic clr;
      assign clr = clearByWrite ? (wrStrobe & wrData[i]) : rdStrobe;
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          flags[i] <= 1'b0;
        end else if (!enable[i]) begin
          flags[i] <= 1'b0;
        end else if (setEvt[i]) begin
          flags[i] <= 1'b1;
        end else if (clr) begin
          flags[i] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule : card_csc_flags
`default_nettype wire

// file: core/card_csc_irq_and_window_enable.sv
// Status-change interrupt configuration and card window enable registers
`timescale 1ns/1ps
`default_nettype none
`include "card_csc_consts.svh"

// Function
// - Select field bits 7-4 routes the combined interrupt: 0 none, 2 SMI, n IRQn.
// - With the diagnostic bit clear the select field routes and PCI-route is ignored.
// - A change on either card-detect pin raises an interrupt only while bit 3 is set.
// - A rising card ready edge raises an interrupt only while bit 2 is set.
// - A battery warning raises an interrupt only while bit 1 is set.
// - Battery dead, or status-change pin on an I/O card, needs bit 0 set.
// - The configuration register sits at 805h and index 05h, resetting to 00h.
// - All windows come out of reset disabled, window register reads 00h.
// - A host cycle to a window with its enable clear is never claimed.
// - Bit 7 enables I/O window 1 and bit 6 enables I/O window 0.
// - Bits 0 to 4 enable memory windows 0 to 4 individually.
// - Bit 5 of the window register is read-only and reads 0.
// - The window register sits at 806h and index 06h.
// - With the diagnostic bit and PCI-route both set, status-change interrupts go to the PCI interrupt.
// - A flag whose source is disabled clears on the clock after its enable bit clears, and reads 0 from then on.
// - Flags clear on read or on write of 1, as the clear mode input picks.
module card_csc_irq_and_window_enable (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Socket register space access
  input wire card_csc_pkg::reg_req_s sockReq,
  // Legacy index access
  input wire card_csc_pkg::reg_req_s legacyReq,
  // Read answer
  output var logic [7:0] rdData,
  output var logic rdValid,
  // Card pins
  input wire logic cardDetectPinA_n,
  input wire logic cardDetectPinB_n,
  input wire logic cardReady,
  input wire logic batteryWarn,
  input wire logic batteryDead,
  input wire logic cardStatusChangePin_n,
  input wire logic cardIsIo,
  // Control bits held elsewhere
  input wire logic diagStatusChangeRoute,
  input wire logic statusChangePciRoute,
  input wire logic flagClearByWrite,
  // Host cycle claim
  input wire card_csc_pkg::cycle_hit_s cycleHit,
  output var logic cycleClaim,
  // Window enables
  output var logic [7:0] windowEnable,
  // Interrupt outputs
  output var logic [15:0] legacyIrq,
  output var logic smiIrq,
  output var logic pciIrq
);

  // ========================================================================
  // Registers
  logic [7:0] cfg_reg;
  logic [7:0] win_reg;
  logic [3:0] flags;
  logic cdA_reg;
  logic cdB_reg;
  logic ready_reg;
  logic warn_reg;
  logic dead_reg;
  logic [3:0] evt_reg;
  logic [3:0] evt_next;

  // ========================================================================
  // Access arbitration and decode
  card_csc_pkg::reg_req_s acc;
  card_csc_pkg::reg_sel_e sel;
  logic fromSock;

  assign fromSock = sockReq.rd | sockReq.wr;
  assign acc = fromSock ? sockReq : legacyReq;

  always_comb begin
    sel = card_csc_pkg::SEL_NONE;
    if (fromSock) begin
      unique case (acc.addr)
        `SOCK_OFS_FLAGS: sel = card_csc_pkg::SEL_FLAGS;
        `SOCK_OFS_CFG: sel = card_csc_pkg::SEL_CFG;
        `SOCK_OFS_WIN: sel = card_csc_pkg::SEL_WIN;
        default: sel = card_csc_pkg::SEL_NONE;
      endcase
    end else begin
      unique case (acc.addr[7:0])
        `LEGACY_IDX_FLAGS: sel = card_csc_pkg::SEL_FLAGS;
        `LEGACY_IDX_CFG: sel = card_csc_pkg::SEL_CFG;
        `LEGACY_IDX_WIN: sel = card_csc_pkg::SEL_WIN;
        default: sel = card_csc_pkg::SEL_NONE;
      endcase
    end
  end

  logic wrCfg;
  logic wrWin;
  logic wrFlags;
  logic rdFlags;

  assign wrCfg = acc.wr && (sel == card_csc_pkg::SEL_CFG);
  assign wrWin = acc.wr && (sel == card_csc_pkg::SEL_WIN);
  assign wrFlags = acc.wr && (sel == card_csc_pkg::SEL_FLAGS);
  assign rdFlags = acc.rd && (sel == card_csc_pkg::SEL_FLAGS);

  // ========================================================================
  // Configuration register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg <= `CFG_RESET;
    end else if (wrCfg) begin
      cfg_reg <= acc.wdata;
    end
  end

  // ========================================================================
  // Window enable register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      win_reg <= `WIN_RESET;
    end else if (wrWin) begin
      win_reg <= acc.wdata & `WIN_WRITE_MASK;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      windowEnable <= `WIN_RESET;
    end else begin
      windowEnable <= win_reg;
    end
  end

  // ========================================================================
  // Read answer
  logic [7:0] rdData_next;

  always_comb begin
    rdData_next = 8'h00;
    unique case (sel)
      card_csc_pkg::SEL_FLAGS: rdData_next = {4'h0, flags};
      card_csc_pkg::SEL_CFG: rdData_next = cfg_reg;
      card_csc_pkg::SEL_WIN: rdData_next = win_reg;
      card_csc_pkg::SEL_NONE: rdData_next = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdValid <= 1'b0;
    end else begin
      rdValid <= acc.rd;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdData <= 8'h00;
    end else if (acc.rd) begin
      rdData <= rdData_next;
    end
  end

  // ========================================================================
  // Pin history
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cdA_reg <= 1'b1;
      cdB_reg <= 1'b1;
    end else begin
      cdA_reg <= cardDetectPinA_n;
      cdB_reg <= cardDetectPinB_n;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ready_reg <= 1'b0;
      warn_reg <= 1'b0;
    end else begin
      ready_reg <= cardReady;
      warn_reg <= batteryWarn;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dead_reg <= 1'b0;
    end else begin
      dead_reg <= cardIsIo ? ~cardStatusChangePin_n : batteryDead;
    end
  end

  // ========================================================================
  // Source events
  logic deadNow;

  assign deadNow = cardIsIo ? ~cardStatusChangePin_n : batteryDead;

  always_comb begin
    evt_next = 4'h0;
    evt_next[`CFG_BIT_CARD_DETECT] = (cardDetectPinA_n ^ cdA_reg)
      | (cardDetectPinB_n ^ cdB_reg);
    evt_next[`CFG_BIT_READY] = ~cardIsIo & cardReady & ~ready_reg;
    evt_next[`CFG_BIT_BATT_WARN] = ~cardIsIo & batteryWarn
      & ~warn_reg;
    evt_next[`CFG_BIT_BATT_DEAD] = deadNow & ~dead_reg;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      evt_reg <= 4'h0;
    end else begin
      evt_reg <= evt_next;
    end
  end

  // ========================================================================
  // Flag store
  card_csc_flags uFlags (
    .mclk(mclk),
    .rst_n(rst_n),
    .setEvt(evt_reg),
    .enable(cfg_reg[`CFG_BIT_CARD_DETECT:`CFG_BIT_BATT_DEAD]),
    .clearByWrite(flagClearByWrite),
    .rdStrobe(rdFlags),
    .wrStrobe(wrFlags),
    .wrData(acc.wdata[3:0]),
    .flags(flags)
  );

  // ========================================================================
  // Interrupt routing
  logic anyFlag;
  logic toPci;
  logic [3:0] select;

  assign anyFlag = |flags;
  assign toPci = diagStatusChangeRoute & statusChangePciRoute;
  assign select = cfg_reg[`CFG_SELECT_MSB:`CFG_SELECT_LSB];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pciIrq <= 1'b0;
    end else begin
      pciIrq <= toPci & anyFlag;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      smiIrq <= 1'b0;
    end else begin
      smiIrq <= ~toPci & anyFlag & (select == `SELECT_SMI);
    end
  end

  logic selectLegacy;

  assign selectLegacy = anyFlag && !toPci && select != `SELECT_NONE
    && select != `SELECT_SMI;

  genvar n;
  generate
    for (n = 0; n < 16; n = n + 1) begin : gIrq
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          legacyIrq[n] <= 1'b0;
        end else begin
          legacyIrq[n] <= selectLegacy && (select == 4'(n));
        end
      end
    end
  endgenerate

  // ========================================================================
  // Host cycle claim
  logic [7:0] hitVec;
  logic [7:0] winHit;

  assign hitVec = {cycleHit.io, 1'b0, cycleHit.mem};

  genvar w;
  generate
    for (w = 0; w < 8; w = w + 1) begin : gWin
      assign winHit[w] = hitVec[w] & win_reg[w];
    end
  endgenerate

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cycleClaim <= 1'b0;
    end else begin
      cycleClaim <= cycleHit.valid & (|winHit);
    end
  end

endmodule : card_csc_irq_and_window_enable
`default_nettype wire

// file: core/card_csc_pkg.sv
// Types shared by the status-change block, its checker and the bench
`default_nettype none
package card_csc_pkg;

  // ========================================================================
  // Register access request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [11:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  // ========================================================================
  // Window hit vector of one host cycle
  typedef struct packed {
    logic valid;
    logic [1:0] io;
    logic [4:0] mem;
  } cycle_hit_s;

  // ========================================================================
  // Register selected by an access
  typedef enum logic [1:0] {
    SEL_NONE = 2'b00,
    SEL_FLAGS = 2'b01,
    SEL_CFG = 2'b10,
    SEL_WIN = 2'b11
  } reg_sel_e;

endpackage : card_csc_pkg
`default_nettype wire

// file: test/card_csc_checker.sv
// Port assertions for the status-change block
`timescale 1ns/1ps
`default_nettype none
module card_csc_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Watched ports
  input wire card_csc_pkg::reg_req_s sockReq,
  input wire card_csc_pkg::reg_req_s legacyReq,
  input wire logic rdValid,
  input wire card_csc_pkg::cycle_hit_s cycleHit,
  input wire logic cycleClaim,
  input wire logic [7:0] windowEnable,
  input wire logic [15:0] legacyIrq,
  input wire logic smiIrq,
  input wire logic pciIrq,
  input wire logic diagStatusChangeRoute,
  input wire logic statusChangePciRoute
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic anyRd;
  logic pciSel;
  logic anySel;
  assign anyRd = sockReq.rd | legacyReq.rd;
  assign pciSel = diagStatusChangeRoute & statusChangePciRoute;
  assign anySel = smiIrq | (|legacyIrq);
  sequence rdAsk; anyRd; endsequence
  sequence rdAns; ##1 rdValid; endsequence
  a_read_answered: assert property (rdAsk |-> rdAns)
    else $error("read not answered");
  a_no_stray_valid: assert property (rdValid |-> $past(anyRd))
    else $error("answer without read");
  a_rsvd_bit_zero: assert property (!windowEnable[5])
    else $error("reserved window bit set");
  a_claim_on_enable: assert property (
    cycleClaim == ($past(cycleHit.valid) && |($past({cycleHit.io,
    cycleHit.mem}) & {windowEnable[7:6], windowEnable[4:0]})))
    else $error("bad claim");
  a_irq_lines_legal: assert property ($onehot0(legacyIrq)
    && !legacyIrq[0] && !legacyIrq[2]) else $error("bad irq line");
  a_single_route: assert property (
    $onehot0({|legacyIrq, smiIrq, pciIrq})) else $error("two routes active");
  a_pci_needs_route: assert property (pciIrq |-> $past(pciSel))
    else $error("pci irq not routed");
  a_select_path_off: assert property (anySel |-> !$past(pciSel))
    else $error("select irq while pci routed");
endmodule : card_csc_checker
`default_nettype wire

// file: test/card_model.sv
// Behavioural 16-bit card driving the socket status pins
`timescale 1ns/1ps
`default_nettype none
module card_model (
  // Clock
  input wire logic mclk,
  // Card pins
  output logic isIo,
  output logic cdA_n,
  output logic cdB_n,
  output logic ready,
  output logic warn,
  output logic dead,
  output logic card_status_change_pin_n
);
  initial {isIo, cdA_n, cdB_n, ready, warn, dead, card_status_change_pin_n} = 7'h01;
  // Pin levels change just after a clock edge
  task automatic set(input logic [6:0] v);
    @(posedge mclk);
    {isIo, cdA_n, cdB_n, ready, warn, dead, card_status_change_pin_n} <= v;
  endtask : set
endmodule : card_model
`default_nettype wire

// file: test/tb_top.sv
// Self-checking bench for the status-change and window enable block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  card_csc_pkg::reg_req_s sockReq = '0;
  card_csc_pkg::reg_req_s legacyReq = '0;
  card_csc_pkg::cycle_hit_s cycleHit = '0;
  logic diag = 1'b0;
  logic pciRoute = 1'b0;
  logic clrWr = 1'b0;
  logic isIo, cdA_n, cdB_n, ready, warn, dead, card_status_change_pin_n;
  logic [7:0] rdData, windowEnable;
  logic rdValid, cycleClaim, smiIrq, pciIrq;
  logic [15:0] legacyIrq;
  logic [6:0] pins = 7'h01;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  always #5 mclk = ~mclk;
  card_model card_u (.mclk(mclk), .isIo(isIo), .cdA_n(cdA_n), .cdB_n(cdB_n),
    .ready(ready), .warn(warn), .dead(dead), .card_status_change_pin_n(card_status_change_pin_n));
  card_csc_irq_and_window_enable dut_u (.mclk(mclk), .rst_n(rst_n),
    .sockReq(sockReq), .legacyReq(legacyReq), .rdData(rdData),
    .rdValid(rdValid), .cardDetectPinA_n(cdA_n), .cardDetectPinB_n(cdB_n),
    .cardReady(ready), .batteryWarn(warn), .batteryDead(dead),
    .cardStatusChangePin_n(card_status_change_pin_n), .cardIsIo(isIo),
    .diagStatusChangeRoute(diag), .statusChangePciRoute(pciRoute),
    .flagClearByWrite(clrWr), .cycleHit(cycleHit), .cycleClaim(cycleClaim),
    .windowEnable(windowEnable), .legacyIrq(legacyIrq), .smiIrq(smiIrq),
    .pciIrq(pciIrq));
  task automatic wrap_up;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic acc(input logic [1:0] k, input logic [11:0] a,
                     input logic [7:0] d, input bit leg);
    @(posedge mclk);
    if (leg) legacyReq <= {k, a, d};
    else sockReq <= {k, a, d};
    @(posedge mclk);
    sockReq <= '0;
    legacyReq <= '0;
  endtask : acc
  task automatic rd(input logic [11:0] a, input bit leg, input logic [7:0] e);
    acc(2'b10, a, 8'h00, leg);
    #1;
    check(rdValid, 1'b1);
    check(rdData, e);
  endtask : rd
  task automatic src(input logic [7:0] cfg, input logic [6:0] v,
                     input logic [17:0] exp, input logic [7:0] flag);
    acc(2'b01, 12'h805, cfg, 1'b0);
    pins = v;
    card_u.set(v);
    repeat (4) @(posedge mclk);
    check({pciIrq, smiIrq, legacyIrq}, exp);
    rd(12'h804, 1'b0, flag);
    repeat (2) @(posedge mclk);
    check({pciIrq, smiIrq, legacyIrq}, 18'h00000);
  endtask : src
  task automatic t_regs;
    check(windowEnable, 8'h00);
    rd(12'h805, 1'b0, 8'h00);
    rd(12'h006, 1'b1, 8'h00);
    acc(2'b01, 12'h805, 8'hA5, 1'b0);
    rd(12'h005, 1'b1, 8'hA5);
    acc(2'b01, 12'h006, 8'hFF, 1'b1);
    rd(12'h806, 1'b0, 8'hDF);
    rd(12'h800, 1'b0, 8'h00);
    check(windowEnable, 8'hDF);
    acc(2'b01, 12'h805, 8'h00, 1'b0);
  endtask : t_regs
  task automatic t_windows;
    logic [7:0] hv;
    for (int i = 0; i < 8; i++) begin
      acc(2'b01, 12'h806, 8'h01 << i, 1'b0);
      for (int j = 0; j < 8; j++) begin
        hv = 8'h01 << j;
        @(posedge mclk);
        cycleHit <= {1'b1, hv[7:6], hv[4:0]};
        @(posedge mclk);
        cycleHit <= '0;
        #1;
        check(cycleClaim, i == j && j != 5);
      end
    end
  endtask : t_windows
  task automatic t_route;
    logic [17:0] e;
    for (int c = 0; c < 16; c++) begin
      e = (c == 0) ? 18'h00000 : (c == 2) ? 18'h10000 : 18'h00001 << c;
      src({c[3:0], 4'h8}, pins ^ 7'h20, e, 8'h08);
    end
    @(posedge mclk);
    diag <= 1'b1;
    pciRoute <= 1'b1;
    src(8'h38, pins ^ 7'h20, 18'h20000, 8'h08);
    @(posedge mclk);
    pciRoute <= 1'b0;
    src(8'h38, pins ^ 7'h10, 18'h00008, 8'h08);
    @(posedge mclk);
    diag <= 1'b0;
    pciRoute <= 1'b1;
    src(8'h38, pins ^ 7'h10, 18'h00008, 8'h08);
  endtask : t_route
  task automatic t_clear;
    @(posedge mclk);
    clrWr <= 1'b1;
    pins = pins ^ 7'h20;
    card_u.set(pins);
    repeat (4) @(posedge mclk);
    rd(12'h804, 1'b0, 8'h08);
    rd(12'h804, 1'b0, 8'h08);
    check(legacyIrq, 16'h0008);
    acc(2'b01, 12'h804, 8'h08, 1'b0);
    repeat (2) @(posedge mclk);
    check(legacyIrq, 16'h0000);
    clrWr <= 1'b0;
  endtask : t_clear
  task automatic t_sources;
    src(8'h30, 7'h09, 18'h00000, 8'h00);
    src(8'h34, 7'h01, 18'h00000, 8'h00);
    src(8'h34, 7'h09, 18'h00008, 8'h04);
    src(8'h32, 7'h0D, 18'h00008, 8'h02);
    src(8'h31, 7'h0F, 18'h00008, 8'h01);
    src(8'h31, 7'h41, 18'h00000, 8'h00);
    src(8'h31, 7'h40, 18'h00008, 8'h01);
  endtask : t_sources
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 8000) begin
      miscompares++;
      wrap_up();
    end
  end
  initial begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    t_regs();
    $display("t_regs done");
    t_windows();
    $display("t_windows done");
    t_route();
    $display("t_route done");
    t_clear();
    $display("t_clear done");
    t_sources();
    $display("t_sources done");
    wrap_up();
  end
endmodule : tb_top
bind card_csc_irq_and_window_enable card_csc_checker chk_u (
  .mclk(mclk), .rst_n(rst_n), .sockReq(sockReq), .legacyReq(legacyReq),
  .rdValid(rdValid), .cycleHit(cycleHit), .cycleClaim(cycleClaim),
  .windowEnable(windowEnable), .legacyIrq(legacyIrq), .smiIrq(smiIrq),
  .pciIrq(pciIrq), .diagStatusChangeRoute(diagStatusChangeRoute),
  .statusChangePciRoute(statusChangePciRoute));
`default_nettype wire
